//--- rtl/bsw_regs.sv
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
// Contract
// - Status bit 21 reads constant one
// - Status bit 23 reads constant one
// - Read parity error sets bit 24 if enabled
// - Parity pin during write sets bit 24 if enabled
// - Split message write parity sets bit 24 if enabled
// - Status bits 26:25 read constant 01
// - Signalled target abort sets bit 27
// - Received target abort sets bit 28
// - Received master abort sets bit 29
// - System error pin sets bit 30
// - Detected parity error sets bit 31 always
// - Prefetch nibbles read 0001 both halves
// - Writable prefetch base in 15:4
// - Writable prefetch limit in 31:20
// - Writable upper base word, resets zero
module bsw_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Secondary bus observations
  input wire bsw_pkg::bsw_evt_t evt,
  input wire logic secondaryParityErrorPinN,
  input wire logic systemErrorPinN,
  // Window settings and interrupt
  output bsw_pkg::bsw_win_t win,
  output logic irq
);
  import bsw_pkg::*;
  `include "bsw_consts.svh"

  bsw_state_t s;
  bsw_state_t next_s;
  logic [`BSW_NFLAGS-1:0] setEv;

  // Status word as software sees it; I/O base/limit half belongs elsewhere
  function automatic logic [31:0] statusWord(input logic [`BSW_NFLAGS-1:0] f);
    logic [31:0] w;
    w = 32'h0;
    w[`BSW_B_M66] = 1'b1;
    w[`BSW_B_FBB] = 1'b1;
    w[`BSW_B_DEVSEL_LO +: 2] = `BSW_DEVSEL_MEDIUM;
    w[`BSW_B_MDPE] = f[`BSW_F_MDPE];
    w[`BSW_B_STA] = f[`BSW_F_STA];
    w[`BSW_B_RTA] = f[`BSW_F_RTA];
    w[`BSW_B_RMA] = f[`BSW_F_RMA];
    w[`BSW_B_RSE] = f[`BSW_F_RSE];
    w[`BSW_B_DPE] = f[`BSW_F_DPE];
    return w;
  endfunction

  function automatic logic [31:0] readMux(input bsw_state_t c);
    logic [31:0] w;
    w = 32'h0;
    case (c.addr)
      `BSW_OFF_SEC_STATUS: begin
        w = statusWord(c.flags);
      end
      `BSW_OFF_MEM_WIN: begin
        w = {c.win.memLimit, 4'h0, c.win.memBase, 4'h0};
      end
      `BSW_OFF_PF_WIN: begin
        w = {c.win.pfLimit, `BSW_ADDR64_CODE, c.win.pfBase, `BSW_ADDR64_CODE};
      end
      `BSW_OFF_PF_HIGH: begin
        w = c.win.pfBaseHigh;
      end
      `BSW_OFF_CTRL: begin
        w[`BSW_CTRL_PEN] = c.win.parityRespEn;
      end
      `BSW_OFF_IRQ_MASK: begin
        w[`BSW_NFLAGS-1:0] = c.irqMask;
      end
      `BSW_OFF_IRQ_STAT: begin
        w[`BSW_NFLAGS-1:0] = c.irqStat;
      end
      default: begin
        w = 32'h0;
      end
    endcase
    return w;
  endfunction

  always_comb begin
    setEv = '0;
    // Enable gates only the master parity flag, not the detected one
    setEv[`BSW_F_MDPE] = s.win.parityRespEn & (evt.rdParityErr
      | (evt.sendingWrite & ~secondaryParityErrorPinN)
      | evt.splitWrParityErr);
    setEv[`BSW_F_STA] = evt.signaledTargetAbort;
    setEv[`BSW_F_RTA] = evt.receivedTargetAbort;
    setEv[`BSW_F_RMA] = evt.receivedMasterAbort;
    setEv[`BSW_F_RSE] = ~systemErrorPinN;
    setEv[`BSW_F_DPE] = evt.parityErrDetected;
  end

  always_comb begin
    next_s = s;
    // Clears are applied before sets so a colliding event survives
    if (s.phase == BSW_WRDATA) begin
      case (s.addr)
        `BSW_OFF_SEC_STATUS: begin
          next_s.flags = s.flags & ~{hwdata[`BSW_B_DPE:`BSW_B_STA], hwdata[`BSW_B_MDPE]};
        end
        `BSW_OFF_MEM_WIN: begin
          next_s.win.memBase = hwdata[`BSW_BASE_LO +: 12];
          next_s.win.memLimit = hwdata[`BSW_LIMIT_LO +: 12];
        end
        `BSW_OFF_PF_WIN: begin
          next_s.win.pfBase = hwdata[`BSW_BASE_LO +: 12];
          next_s.win.pfLimit = hwdata[`BSW_LIMIT_LO +: 12];
        end
        `BSW_OFF_PF_HIGH: begin
          next_s.win.pfBaseHigh = hwdata;
        end
        `BSW_OFF_CTRL: begin
          next_s.win.parityRespEn = hwdata[`BSW_CTRL_PEN];
        end
        `BSW_OFF_IRQ_MASK: begin
          next_s.irqMask = hwdata[`BSW_NFLAGS-1:0];
        end
        default: begin
        end
      endcase
    end
    // Read data is taken a cycle late so a just-written value is seen
    if (s.phase == BSW_RDWAIT) begin
      next_s.hrdata = readMux(s);
      if (s.addr == `BSW_OFF_IRQ_STAT) begin
        next_s.irqStat = '0;
      end
    end
    next_s.flags = next_s.flags | setEv;
    next_s.irqStat = next_s.irqStat | setEv;
    case (s.phase)
      BSW_RDWAIT: begin
        next_s.phase = BSW_RDDONE;
      end
      default: begin
        if (hsel && htrans[1] && hready) begin
          next_s.addr = {haddr[7:2], 2'h0};
          next_s.phase = hwrite ? BSW_WRDATA : BSW_RDWAIT;
        end else begin
          next_s.phase = BSW_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout = (s.phase != BSW_RDWAIT);
  assign hresp = 1'b0;
  assign hrdata = s.hrdata;
  assign win = s.win;
  assign irq = |(s.irqStat & s.irqMask);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic rdStatus;
  logic rdPf;
  assign rdStatus = (s.phase == BSW_RDDONE) && (s.addr == `BSW_OFF_SEC_STATUS);
  assign rdPf = (s.phase == BSW_RDDONE) && (s.addr == `BSW_OFF_PF_WIN);

  m66_const_a: assert property (rdStatus |-> hrdata[`BSW_B_M66])
    else $error("status bit 21 not one");
  fbb_const_a: assert property (rdStatus |-> hrdata[`BSW_B_FBB])
    else $error("status bit 23 not one");
  devsel_const_a: assert property (rdStatus |-> hrdata[26:25] == 2'h1)
    else $error("devsel timing not 01");
  mdpe_gate_a: assert property ((!s.win.parityRespEn && !s.flags[`BSW_F_MDPE]) |=> !s.flags[`BSW_F_MDPE])
    else $error("master parity set while disabled");
  mdpe_pin_a: assert property ((s.win.parityRespEn && evt.sendingWrite && !secondaryParityErrorPinN)
      |=> s.flags[`BSW_F_MDPE])
    else $error("parity pin during write not flagged");
  mdpe_split_a: assert property ((s.win.parityRespEn && evt.splitWrParityErr) |=> s.flags[`BSW_F_MDPE])
    else $error("split parity message not flagged");
  sta_set_a: assert property (evt.signaledTargetAbort |=> s.flags[`BSW_F_STA])
    else $error("signalled target abort not flagged");
  rta_set_a: assert property (evt.receivedTargetAbort |=> s.flags[`BSW_F_RTA])
    else $error("received target abort not flagged");
  rma_set_a: assert property (evt.receivedMasterAbort |=> s.flags[`BSW_F_RMA])
    else $error("master abort not flagged");
  rse_set_a: assert property (!systemErrorPinN |=> s.flags[`BSW_F_RSE])
    else $error("system error not flagged");
  dpe_set_a: assert property (evt.parityErrDetected |=> s.flags[`BSW_F_DPE])
    else $error("detected parity not flagged");
  pf_code_a: assert property (rdPf |-> (hrdata[3:0] == 4'h1 && hrdata[19:16] == 4'h1))
    else $error("prefetch addressing code wrong");
  pf_write_a: assert property ((s.phase == BSW_WRDATA && s.addr == `BSW_OFF_PF_WIN)
      |=> (win.pfBase == $past(hwdata[15:4]) && win.pfLimit == $past(hwdata[31:20])))
    else $error("prefetch window write lost");
  pf_high_a: assert property ((s.phase == BSW_WRDATA && s.addr == `BSW_OFF_PF_HIGH)
      |=> win.pfBaseHigh == $past(hwdata))
    else $error("upper base write lost");
  w1c_clear_a: assert property ((s.phase == BSW_WRDATA && s.addr == `BSW_OFF_SEC_STATUS
      && hwdata[`BSW_B_STA] && !evt.signaledTargetAbort) |=> !s.flags[`BSW_F_STA])
    else $error("write one did not clear flag");
  w0_keep_a: assert property ((s.phase == BSW_WRDATA && s.addr == `BSW_OFF_SEC_STATUS
      && !hwdata[`BSW_B_RTA] && s.flags[`BSW_F_RTA]) |=> s.flags[`BSW_F_RTA])
    else $error("write zero changed flag");
  mem_low_a: assert property ((s.phase == BSW_RDDONE && s.addr == `BSW_OFF_MEM_WIN)
      |-> (hrdata[3:0] == 4'h0 && hrdata[19:16] == 4'h0))
    else $error("memory window reserved bits set");
  rd_wait_a: assert property ((hsel && htrans[1] && hready && !hwrite && hreadyout)
      |=> !hreadyout ##1 hreadyout)
    else $error("read latency wrong");

  // Decoded phases shared by the checks below
  logic wrPhase;
  logic rdWait;
  logic rdDone;
  logic wrStatus;
  logic [`BSW_NFLAGS-1:0] clrBits;
  assign wrPhase = (s.phase == BSW_WRDATA);
  assign rdWait = (s.phase == BSW_RDWAIT);
  assign rdDone = (s.phase == BSW_RDDONE);
  assign wrStatus = wrPhase && (s.addr == `BSW_OFF_SEC_STATUS);
  assign clrBits = {hwdata[`BSW_B_DPE:`BSW_B_STA], hwdata[`BSW_B_MDPE]};

  // Only the read's wait cycle may stall; an error response is never given
  hresp_okay_a: assert property (hresp == 1'b0)
    else $error("error response driven");
  wr_ready_a: assert property (wrPhase |-> hreadyout)
    else $error("write data phase stalled");
  idle_ready_a: assert property ((s.phase == BSW_IDLE) |-> hreadyout)
    else $error("idle bus not ready");
  rd_stall_a: assert property (rdWait |-> (!hreadyout ##1 (rdDone && hreadyout)))
    else $error("read wait cycle not single");
  rd_start_a: assert property ((hsel && htrans[1] && hready && !hwrite)
      |=> rdWait)
    else $error("read address phase not taken");
  wr_start_a: assert property ((hsel && htrans[1] && hready && hwrite)
      |=> wrPhase)
    else $error("write address phase not taken");
  no_start_a: assert property ((!(hsel && htrans[1]) && !rdWait)
      |=> (s.phase == BSW_IDLE))
    else $error("phase moved without a request");
  addr_take_a: assert property ((hsel && htrans[1] && hready && !rdWait)
      |=> (s.addr[7:2] == $past(haddr[7:2])))
    else $error("address not captured");
  addr_hold_a: assert property ((!(hsel && htrans[1] && hready) || rdWait)
      |=> $stable(s.addr))
    else $error("address moved without a request");
  hrdata_hold_a: assert property (!rdDone |-> $stable(hrdata))
    else $error("read data changed outside a read");

  // Set beats a write-one clear; nothing else moves a sticky flag
  flag_set_a: assert property ((setEv != '0)
      |=> ((s.flags & $past(setEv)) == $past(setEv)))
    else $error("event lost in status flags");
  flag_hold_a: assert property (!wrStatus
      |=> (s.flags == ($past(s.flags) | $past(setEv))))
    else $error("status flag moved without cause");
  w1c_all_a: assert property (wrStatus
      |=> (s.flags == (($past(s.flags) & ~$past(clrBits)) | $past(setEv))))
    else $error("write one clear wrong");
  mdpe_rd_a: assert property ((s.win.parityRespEn && evt.rdParityErr)
      |=> s.flags[`BSW_F_MDPE])
    else $error("read parity error not flagged");
  mdpe_nopin_a: assert property ((!s.flags[`BSW_F_MDPE] && !evt.sendingWrite && !evt.rdParityErr
      && !evt.splitWrParityErr) |=> !s.flags[`BSW_F_MDPE])
    else $error("parity pin outside a write flagged");
  dpe_ungated_a: assert property ((!s.win.parityRespEn && evt.parityErrDetected)
      |=> s.flags[`BSW_F_DPE])
    else $error("detected parity gated by enable");
  sta_quiet_a: assert property ((!s.flags[`BSW_F_STA] && !evt.signaledTargetAbort)
      |=> !s.flags[`BSW_F_STA])
    else $error("signalled abort flag set without cause");
  rta_quiet_a: assert property ((!s.flags[`BSW_F_RTA] && !evt.receivedTargetAbort)
      |=> !s.flags[`BSW_F_RTA])
    else $error("received abort flag set without cause");
  rma_quiet_a: assert property ((!s.flags[`BSW_F_RMA] && !evt.receivedMasterAbort)
      |=> !s.flags[`BSW_F_RMA])
    else $error("master abort flag set without cause");
  rse_quiet_a: assert property ((!s.flags[`BSW_F_RSE] && systemErrorPinN)
      |=> !s.flags[`BSW_F_RSE])
    else $error("system error flag set without cause");
  dpe_quiet_a: assert property ((!s.flags[`BSW_F_DPE] && !evt.parityErrDetected)
      |=> !s.flags[`BSW_F_DPE])
    else $error("detected parity flag set without cause");
  status_mirror_a: assert property (rdStatus
      |-> ({hrdata[`BSW_B_DPE:`BSW_B_STA], hrdata[`BSW_B_MDPE]} == $past(s.flags)))
    else $error("status flags read back wrong");
  status_rsvd_a: assert property (rdStatus |-> (hrdata[22] == 1'b0 && hrdata[20:0] == 21'h0))
    else $error("status reserved bits set");

  // Window registers change only in a write data phase to their own offset
  win_hold_a: assert property (!wrPhase |=> $stable(win))
    else $error("window changed without a write");
  mem_write_a: assert property ((wrPhase && s.addr == `BSW_OFF_MEM_WIN)
      |=> ({win.memLimit, 4'h0, win.memBase, 4'h0} == ($past(hwdata) & 32'hfff0fff0)))
    else $error("memory window write lost");
  mem_read_a: assert property ((rdDone && s.addr == `BSW_OFF_MEM_WIN)
      |-> ({hrdata[31:20], hrdata[15:4]} == {$past(win.memLimit), $past(win.memBase)}))
    else $error("memory window read back wrong");
  pf_base_rd_a: assert property ((rdDone && s.addr == `BSW_OFF_PF_WIN)
      |-> (hrdata[15:4] == $past(win.pfBase)))
    else $error("prefetch base read back wrong");
  pf_limit_rd_a: assert property ((rdDone && s.addr == `BSW_OFF_PF_WIN)
      |-> (hrdata[31:20] == $past(win.pfLimit)))
    else $error("prefetch limit read back wrong");
  pf_limit_wr_a: assert property ((wrPhase && s.addr == `BSW_OFF_PF_WIN)
      |=> (win.pfLimit == $past(hwdata[31:20])))
    else $error("prefetch limit write lost");
  pf_high_rd_a: assert property ((rdDone && s.addr == `BSW_OFF_PF_HIGH)
      |-> (hrdata == $past(win.pfBaseHigh)))
    else $error("upper base read back wrong");
  pf_high_hold_a: assert property (!(wrPhase && s.addr == `BSW_OFF_PF_HIGH)
      |=> $stable(win.pfBaseHigh))
    else $error("upper base changed without a write");
  ctrl_write_a: assert property ((wrPhase && s.addr == `BSW_OFF_CTRL)
      |=> (win.parityRespEn == $past(hwdata[`BSW_CTRL_PEN])))
    else $error("parity enable write lost");
  ctrl_read_a: assert property ((rdDone && s.addr == `BSW_OFF_CTRL)
      |-> (hrdata == {31'h0, $past(win.parityRespEn)}))
    else $error("parity enable read back wrong");
  unmapped_rd_a: assert property ((rdDone && !(s.addr inside {`BSW_OFF_SEC_STATUS, `BSW_OFF_MEM_WIN,
      `BSW_OFF_PF_WIN, `BSW_OFF_PF_HIGH, `BSW_OFF_CTRL, `BSW_OFF_IRQ_MASK, `BSW_OFF_IRQ_STAT}))
      |-> (hrdata == 32'h0))
    else $error("unmapped offset read not zero");

  // Interrupt status is a read-clear copy of the flag events
  stat_set_a: assert property ((setEv != '0)
      |=> ((s.irqStat & $past(setEv)) == $past(setEv)))
    else $error("event lost in interrupt status");
  stat_hold_a: assert property (!(rdWait && s.addr == `BSW_OFF_IRQ_STAT)
      |=> (s.irqStat == ($past(s.irqStat) | $past(setEv))))
    else $error("interrupt status moved without cause");
  stat_clear_a: assert property ((rdWait && s.addr == `BSW_OFF_IRQ_STAT && setEv == '0)
      |=> (s.irqStat == '0))
    else $error("interrupt status not cleared by read");
  stat_read_a: assert property ((rdDone && s.addr == `BSW_OFF_IRQ_STAT)
      |-> (hrdata == {26'h0, $past(s.irqStat)}))
    else $error("interrupt status read back wrong");
  mask_write_a: assert property ((wrPhase && s.addr == `BSW_OFF_IRQ_MASK)
      |=> (s.irqMask == $past(hwdata[`BSW_NFLAGS-1:0])))
    else $error("interrupt mask write lost");
  mask_hold_a: assert property (!(wrPhase && s.addr == `BSW_OFF_IRQ_MASK)
      |=> $stable(s.irqMask))
    else $error("interrupt mask changed without a write");
  mask_read_a: assert property ((rdDone && s.addr == `BSW_OFF_IRQ_MASK)
      |-> (hrdata == {26'h0, $past(s.irqMask)}))
    else $error("interrupt mask read back wrong");
  irq_raise_a: assert property ((((setEv & s.irqMask) != '0) && !(wrPhase && s.addr == `BSW_OFF_IRQ_MASK))
      |=> irq)
    else $error("unmasked event gave no interrupt");
  irq_masked_a: assert property ((s.irqMask == '0) |-> !irq)
    else $error("interrupt with every source masked");

  wr_cov_c: cover property (s.phase == BSW_WRDATA && s.addr == `BSW_OFF_PF_HIGH);
  rd_cov_c: cover property (rdStatus && hrdata[`BSW_B_DPE]);
  irq_cov_c: cover property ($rose(irq));
  race_cov_c: cover property (s.phase == BSW_WRDATA && s.addr == `BSW_OFF_SEC_STATUS
    && hwdata[`BSW_B_STA] && evt.signaledTargetAbort);
  mem_cov_c: cover property (s.phase == BSW_RDDONE && s.addr == `BSW_OFF_MEM_WIN
    && hrdata[31:20] != 12'h0);
endmodule

//--- rtl/bsw_consts.svh
`ifndef BSW_CONSTS_SVH
`define BSW_CONSTS_SVH

// Byte offsets on the register bus
`define BSW_OFF_SEC_STATUS 8'h1c
`define BSW_OFF_MEM_WIN 8'h20
`define BSW_OFF_PF_WIN 8'h24
`define BSW_OFF_PF_HIGH 8'h28
`define BSW_OFF_CTRL 8'h40
`define BSW_OFF_IRQ_MASK 8'h44
`define BSW_OFF_IRQ_STAT 8'h48

// Secondary status bit positions within the word
`define BSW_B_M66 21
`define BSW_B_FBB 23
`define BSW_B_MDPE 24
`define BSW_B_DEVSEL_LO 25
`define BSW_B_STA 27
`define BSW_B_RTA 28
`define BSW_B_RMA 29
`define BSW_B_RSE 30
`define BSW_B_DPE 31
`define BSW_DEVSEL_MEDIUM 2'h1

// Sticky flag indices (same layout in irq status and mask)
`define BSW_F_MDPE 0
`define BSW_F_STA 1
`define BSW_F_RTA 2
`define BSW_F_RMA 3
`define BSW_F_RSE 4
`define BSW_F_DPE 5
`define BSW_NFLAGS 6

// Window register layout
`define BSW_BASE_LO 4
`define BSW_LIMIT_LO 20
`define BSW_ADDR64_CODE 4'h1
`define BSW_CTRL_PEN 0

`endif

//--- rtl/bsw_pkg.sv
package bsw_pkg;
  `include "bsw_consts.svh"

  typedef enum logic [1:0] {
    BSW_IDLE = 2'h0,
    BSW_WRDATA = 2'h1,
    BSW_RDWAIT = 2'h3,
    BSW_RDDONE = 2'h2
  } bsw_phase_t;

  // Secondary bus events, each a one-cycle pulse or level per cycle
  typedef struct packed {
    logic rdParityErr;
    logic sendingWrite;
    logic splitWrParityErr;
    logic signaledTargetAbort;
    logic receivedTargetAbort;
    logic receivedMasterAbort;
    logic parityErrDetected;
  } bsw_evt_t;

  // Window settings presented to the forwarding logic
  typedef struct packed {
    logic [11:0] memBase;
    logic [11:0] memLimit;
    logic [11:0] pfBase;
    logic [11:0] pfLimit;
    logic [31:0] pfBaseHigh;
    logic parityRespEn;
  } bsw_win_t;

  typedef struct packed {
    bsw_phase_t phase;
    logic [7:0] addr;
    logic [31:0] hrdata;
    logic [`BSW_NFLAGS-1:0] flags;
    logic [`BSW_NFLAGS-1:0] irqStat;
    logic [`BSW_NFLAGS-1:0] irqMask;
    bsw_win_t win;
  } bsw_state_t;
endpackage

//--- dv/bsw_sec_agent.sv
`timescale 1ns/1ps
module bsw_sec_agent (
  // Clock
  input wire logic clk,
  // Commands from the bench: {system error, parity pin, event bits}
  input wire logic [8:0] fire,
  // Secondary bus observations
  output bsw_pkg::bsw_evt_t evt,
  output logic secondaryParityErrorPinN,
  output logic systemErrorPinN
);
  import bsw_pkg::*;

  // Both error lines are pulled up on the bus, so they idle high between events
  initial begin
    evt = '0;
    secondaryParityErrorPinN = 1'b1;
    systemErrorPinN = 1'b1;
  end

  // One registered cycle per command; the pin pulse only comes with sendingWrite in the table
  always @(posedge clk) begin
    evt <= fire[6:0];
    secondaryParityErrorPinN <= ~fire[7];
    systemErrorPinN <= ~fire[8];
  end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin nMismatch++; $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  import bsw_pkg::*;
  localparam logic [31:0] StatBase = 32'h02a00000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hresp;
  logic irq;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [8:0] fire = 9'h0;
  bsw_evt_t evt;
  logic perrN;
  logic serrN;
  bsw_win_t win;
  int nMismatch = 0;
  int cmpCount = 0;
  logic [8:0] evTab [8] = '{9'h040, 9'h0a0, 9'h010, 9'h008, 9'h004, 9'h002, 9'h100, 9'h001};
  int bitTab [8] = '{24, 24, 24, 27, 28, 29, 30, 31};

  always #2 clk = ~clk;

  bsw_regs i_dut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .evt(evt), .secondaryParityErrorPinN(perrN), .systemErrorPinN(serrN),
    .win(win), .irq(irq)
  );

  bsw_sec_agent i_agent (
    .clk(clk), .fire(fire), .evt(evt), .secondaryParityErrorPinN(perrN), .systemErrorPinN(serrN)
  );

  // Single AHB-Lite transfer; the master never assumes a latency
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    d = hrdata;
  endtask

  task automatic pulse(input logic [8:0] f);
    @(posedge clk);
    fire <= f;
    @(posedge clk);
    fire <= 9'h0;
    repeat (3) @(posedge clk);
  endtask

  task automatic endOfTest;
    $display("Comparisons %0d, mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #20000;
    nMismatch++;
    endOfTest;
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    ahb(1'b0, 8'h1c, 32'h0, rd);
    `CHK(rd, StatBase)
    ahb(1'b0, 8'h20, 32'h0, rd);
    `CHK(rd, 32'h0)
    ahb(1'b0, 8'h24, 32'h0, rd);
    `CHK(rd, 32'h00010001)
    ahb(1'b0, 8'h28, 32'h0, rd);
    `CHK(rd, 32'h0)
    ahb(1'b1, 8'h20, 32'hffffffff, rd);
    ahb(1'b0, 8'h20, 32'h0, rd);
    `CHK(rd, 32'hfff0fff0)
    ahb(1'b1, 8'h24, 32'hffffffff, rd);
    ahb(1'b0, 8'h24, 32'h0, rd);
    `CHK(rd, 32'hfff1fff1)
    ahb(1'b1, 8'h28, 32'ha5c33c5a, rd);
    ahb(1'b0, 8'h28, 32'h0, rd);
    `CHK(rd, 32'ha5c33c5a)
    `CHK(win.pfBase, 12'hfff)
    `CHK(win.pfLimit, 12'hfff)
    `CHK(win.pfBaseHigh, 32'ha5c33c5a)
    `CHK({win.memLimit, win.memBase}, 24'hffffff)
    `CHK(hresp, 1'b0)
    ahb(1'b0, 8'h30, 32'h0, rd);
    `CHK(rd, 32'h0)
    // Parity response still disabled: master parity sources must be ignored
    pulse(9'h040);
    pulse(9'h0a0);
    pulse(9'h010);
    ahb(1'b0, 8'h1c, 32'h0, rd);
    `CHK(rd, StatBase)
    pulse(9'h001);
    ahb(1'b0, 8'h1c, 32'h0, rd);
    `CHK(rd, StatBase | 32'h80000000)
    ahb(1'b1, 8'h1c, 32'h80000000, rd);
    ahb(1'b0, 8'h1c, 32'h0, rd);
    `CHK(rd, StatBase)
    ahb(1'b0, 8'h48, 32'h0, rd);
    `CHK(rd, 32'h20)
    ahb(1'b1, 8'h40, 32'h1, rd);
    ahb(1'b0, 8'h40, 32'h0, rd);
    `CHK(rd, 32'h1)
    `CHK(win.parityRespEn, 1'b1)
    for (int i = 0; i < 8; i++) begin
      pulse(evTab[i]);
      ahb(1'b1, 8'h1c, 32'h0, rd);
      ahb(1'b0, 8'h1c, 32'h0, rd);
      `CHK(rd, StatBase | (32'h1 << bitTab[i]))
      ahb(1'b1, 8'h1c, 32'h1 << bitTab[i], rd);
      ahb(1'b0, 8'h1c, 32'h0, rd);
      `CHK(rd, StatBase)
    end
    ahb(1'b0, 8'h48, 32'h0, rd);
    `CHK(rd, 32'h3f)
    ahb(1'b0, 8'h48, 32'h0, rd);
    `CHK(rd, 32'h0)
    `CHK(irq, 1'b0)
    // Only the signalled target abort is unmasked
    ahb(1'b1, 8'h44, 32'h2, rd);
    ahb(1'b0, 8'h44, 32'h0, rd);
    `CHK(rd, 32'h2)
    pulse(9'h004);
    `CHK(irq, 1'b0)
    pulse(9'h008);
    `CHK(irq, 1'b1)
    ahb(1'b0, 8'h48, 32'h0, rd);
    `CHK(rd, 32'h6)
    `CHK(irq, 1'b0)
    endOfTest;
  end
endmodule
